// ==== bench/tb_top.sv ====
// Self-checking bench of the wait-state generator.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
    reg clk = 0, rst = 1, wr = 0, rd = 0, sel = 0, own = 1, st = 0, ce = 1'b1;
    reg [7:0] ad = 0;
    reg [15:0] wd = 0;
    reg [1:0] sp = 0;
    reg [18:0] aa = 0;
    reg [3:0] need = 0;
    reg [26:0] rows [0:10];
    wire [15:0] rdat;
    wire hold, stall, done, late;
    wire [3:0] wc;
    integer num_errors = 0, samples_checked = 0, i, k;
    always #12.5 clk = ~clk;
    wsg_top wsg_top_i(.REF_CLK(clk), .RESET(rst), .CE(ce), .REG_ADDR(ad), .REG_SEL_B(sel),
        .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdat), .OWNER_B(own),
        .ACC_START(st), .ACC_SPACE(sp), .ACC_ADDR(aa), .BUS_HOLD(hold), .CPU_STALL(stall),
        .ACC_DONE(done), .WAIT_COUNT(wc));
    wsg_mem wsg_mem_i(.clk(clk), .hold(hold), .done(done), .need(need), .late(late));
    // Each strobe task first waits one falling edge, so two calls in a row never
    // lower and raise the same strobe in one time step.
    task wreg(input s, input [7:0] a, input [15:0] d); begin
        @(negedge clk);
        sel = s;
        ad = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk) wr = 1'b0;
    end endtask
    task rreg(input s, input [7:0] a, input [15:0] e); begin
        @(negedge clk);
        sel = s;
        ad = a;
        rd = 1'b1;
        @(negedge clk) rd = 1'b0;
        @(negedge clk) `CHK(rdat, e)
    end endtask
    task acc(input [1:0] s, input [18:0] a, input [3:0] e); begin
        @(negedge clk);
        sp = s;
        aa = a;
        need = e;
        st = 1'b1;
        @(negedge clk) st = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
        `CHK({done, wc}, {1'b1, e})
        @(negedge clk) `CHK(late, 1'b0)
    end endtask
    task end_of_test; begin
        $display("num_errors %0d samples_checked %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end endtask
    initial begin
        rows[0] = {4'h0, 19'h08000, 4'h4};
        rows[1] = {4'h0, 19'h00001, 4'h5};
        rows[2] = {4'h0, 19'h18000, 4'h4};
        rows[3] = {4'h1, 19'h08000, 4'h2};
        rows[4] = {4'h1, 19'h07fff, 4'h3};
        rows[5] = {4'h2, 19'h0ffff, 4'h1};
        rows[6] = {4'h4, 19'h28000, 4'h5};
        rows[7] = {4'h4, 19'h40000, 4'h0};
        rows[8] = {4'ha, 19'h00000, 4'h2};
        rows[9] = {4'h8, 19'h00010, 4'ha};
        rows[10] = {4'h3, 19'h00000, 4'h0};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rreg(0, 8'h28, 16'h7fff);
        rreg(1, 8'h2b, 16'h0000);
        wreg(1, 8'h2b, 16'hffff);
        rreg(1, 8'h2b, 16'h0001);
        rreg(1, 8'h29, 16'h0000);
        for (i = 0; i < 11; i++) begin
            wreg(1, 8'h28, {rows[i][25], 15'h14e5});
            wreg(1, 8'h2b, {15'h0, rows[i][26]});
            rreg(1, 8'h28, {rows[i][25], 15'h14e5});
            acc(rows[i][24:23], rows[i][22:4], rows[i][3:0]);
        end
        own = 1'b0;
        acc(2'h2, 19'h00000, 4'h7);
        wreg(0, 8'h2b, 16'h0001);
        acc(2'h0, 19'h08000, 4'he);
        // A write with the clock enable low must leave the register alone.
        ce = 1'b0;
        wreg(0, 8'h28, 16'h0000);
        ce = 1'b1;
        rreg(0, 8'h28, 16'h7fff);
        rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        rreg(1, 8'h28, 16'h7fff);
        rreg(0, 8'h2b, 16'h0000);
        end_of_test;
    end
    initial begin
        #50000;
        num_errors++;
        end_of_test;
    end
endmodule

// ==== bench/wsg_mem.sv ====
// Slow memory that flags a cycle released before its access time.
`timescale 1ns/1ps
module wsg_mem (
    input wire clk,
    input wire hold,
    input wire done,
    input wire [3:0] need,
    output reg late
);
    reg [3:0] n = 4'h0;
    initial late = 1'b0;
    always @(posedge clk) begin
        n <= hold ? n + 4'h1 : 4'h0;
        late <= done && n < need;
    end
endmodule

// ==== bench/wsg_props.sv ====
// Port checks for the wait-state generator.
`timescale 1ns/1ps
module wsg_props (
    input wire REF_CLK,
    input wire RESET,
    input wire CE,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [15:0] REG_RDATA,
    input wire ACC_START,
    input wire BUS_HOLD,
    input wire CPU_STALL,
    input wire ACC_DONE,
    input wire [3:0] WAIT_COUNT
);
    reg [3:0] hc;
    // Counts the cycles of the current hold; frozen while the enable is low.
    always @(posedge REF_CLK) begin
        if (RESET || !BUS_HOLD)
            hc <= 4'h0;
        else if (CE)
            hc <= hc + 4'h1;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET || !CE);
    property p_len; $fell(BUS_HOLD) |-> hc == WAIT_COUNT; endproperty
    a_len: assert property (p_len) else $error("hold length off");
    property p_start; $rose(BUS_HOLD) |-> $past(ACC_START, 2) && WAIT_COUNT != 4'h0; endproperty
    a_start: assert property (p_start) else $error("hold without start");
    property p_end; $fell(BUS_HOLD) |-> ACC_DONE; endproperty
    a_end: assert property (p_end) else $error("done late");
    property p_pulse; ACC_DONE |=> !ACC_DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_stall; CPU_STALL == BUS_HOLD; endproperty
    a_stall: assert property (p_stall) else $error("stall differs");
    property p_max; WAIT_COUNT <= 4'he; endproperty
    a_max: assert property (p_max) else $error("count too big");
    property p_quiet; BUS_HOLD |-> !ACC_DONE; endproperty
    a_quiet: assert property (p_quiet) else $error("done in hold");
    property p_res; $past(REG_RD) && $past(REG_ADDR) == 8'h2b |-> REG_RDATA[15:1] == 15'h0;
    endproperty
    a_res: assert property (p_res) else $error("reserved bits set");
endmodule
bind wsg_top wsg_props wsg_props_i(.REF_CLK, .RESET, .CE, .REG_RD, .REG_ADDR, .REG_RDATA,
    .ACC_START, .BUS_HOLD, .CPU_STALL, .ACC_DONE, .WAIT_COUNT);

// ==== verilog/wsg_counter.v ====
// Wait-state down counter that holds the external cycle and stalls the CPU.
`timescale 1ns/1ps
module wsg_counter (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire start,
    input wire [3:0] count,
    output reg busy,
    output reg done
);
    reg [3:0] remain;

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            remain <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (!busy && start) begin
                if (count == 4'h0) begin
                    done <= 1'b1;
                end else begin
                    remain <= count;
                    busy <= 1'b1;
                end
            end else if (busy) begin
                if (remain == 4'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                remain <= remain - 4'h1;
            end
        end
    end
endmodule

// ==== verilog/wsg_defs.vh ====
// Register offsets, field positions, reset values and codes for the wait-state generator.
`ifndef WSG_DEFS_VH
`define WSG_DEFS_VH

// ----------------------------------------------------------------------------
// Register map (word offsets on the CPU-mapped register port)
// ----------------------------------------------------------------------------
`define WSG_ADDR_W 8
`define WSG_OFS_RANGE 8'h28
`define WSG_OFS_CTRL 8'h2b

// ----------------------------------------------------------------------------
// Range register fields
// ----------------------------------------------------------------------------
`define WSG_XPROG_BIT 15
`define WSG_IO_LSB 4'hc
`define WSG_DHI_LSB 4'h9
`define WSG_DLO_LSB 4'h6
`define WSG_PHI_LSB 4'h3
`define WSG_PLO_LSB 4'h0
`define WSG_FIELD_W 3
`define WSG_RANGE_RESET 16'h7fff
`define WSG_RANGE_WMASK 16'hffff

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define WSG_DBL_BIT 0
`define WSG_CTRL_RESET 16'h0000
`define WSG_CTRL_WMASK 16'h0001

// ----------------------------------------------------------------------------
// Access spaces and program split
// ----------------------------------------------------------------------------
`define WSG_SP_PROG 2'h0
`define WSG_SP_DATA 2'h1
`define WSG_SP_IO 2'h2
`define WSG_ADDR_HALF_BIT 15
`define WSG_XPROG_LIMIT 19'h3ffff
`define WSG_MAX_WAIT 4'he

`endif

// ==== verilog/wsg_top.v ====
// Programmable wait-state generator for the external bus of one DSP subsystem pair.
`timescale 1ns/1ps
`include "wsg_defs.vh"
module wsg_top (
    input wire REF_CLK,
    input wire RESET,
    input wire CE,
    // CPU-mapped register port.
    input wire [7:0] REG_ADDR,
    input wire REG_SEL_B,
    input wire REG_WR,
    input wire REG_RD,
    input wire [15:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    // External access request from the bus interface.
    input wire OWNER_B,
    input wire ACC_START,
    input wire [1:0] ACC_SPACE,
    input wire [18:0] ACC_ADDR,
    // Wait-state status.
    output reg BUS_HOLD,
    output reg CPU_STALL,
    output reg ACC_DONE,
    output reg [3:0] WAIT_COUNT
);
    reg [15:0] range_set [0:1];
    reg [15:0] ctrl_set [0:1];
    wire hit_range;
    wire hit_ctrl;
    wire wr_en;
    wire rd_en;
    wire [15:0] own_range;
    wire own_dbl;
    wire [3:0] next_wait;
    wire start_ok;
    wire ctr_busy;
    wire ctr_done;

    // ------------------------------------------------------------------------
    // Field extraction shared by all ranges
    // ------------------------------------------------------------------------
    // Returns the three-bit base count that starts at bit lsb.
    function [2:0] field;
        input [15:0] r;
        input [3:0] lsb;
        reg [15:0] sh;
        begin
            sh = r >> lsb;
            field = sh[2:0];
        end
    endfunction

    // Base count of a program access. A program access beyond the extended
    // range gets no wait states.
    function [2:0] prog_base;
        input [15:0] r;
        input [18:0] a;
        begin
            if (r[`WSG_XPROG_BIT]) begin
                // Outside the extended range no field applies.
                if (a <= `WSG_XPROG_LIMIT)
                    prog_base = field(r, `WSG_PLO_LSB);
                else
                    prog_base = 3'h0;
            end else if (a[`WSG_ADDR_HALF_BIT]) begin
                prog_base = field(r, `WSG_PHI_LSB);
            end else begin
                prog_base = field(r, `WSG_PLO_LSB);
            end
        end
    endfunction

    // Base count of a data access, split at the middle of data space.
    function [2:0] data_base;
        input [15:0] r;
        input [18:0] a;
        begin
            if (a[`WSG_ADDR_HALF_BIT])
                data_base = field(r, `WSG_DHI_LSB);
            else
                data_base = field(r, `WSG_DLO_LSB);
        end
    endfunction

    // Applies the doubler; seven doubled is the fourteen-wait ceiling.
    function [3:0] scale;
        input [2:0] base;
        input dbl;
        begin
            if (dbl)
                scale = {base, 1'b0};
            else
                scale = {1'b0, base};
        end
    endfunction

    // Wait count of an access, after the doubler.
    function [3:0] pick;
        input [15:0] r;
        input [1:0] sp;
        input [18:0] a;
        input dbl;
        reg [2:0] base;
        begin
            case (sp)
                `WSG_SP_IO: base = field(r, `WSG_IO_LSB);
                `WSG_SP_DATA: base = data_base(r, a);
                `WSG_SP_PROG: base = prog_base(r, a);
                default: base = 3'h0;
            endcase
            pick = scale(base, dbl);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Register address decode, shared by the write and read paths
    // ------------------------------------------------------------------------
    // Both paths decode the word offset alone; other offsets are ignored on
    // write and read as zero.
    assign hit_range = (REG_ADDR == `WSG_OFS_RANGE);
    assign hit_ctrl = (REG_ADDR == `WSG_OFS_CTRL);
    assign wr_en = CE && REG_WR;
    assign rd_en = CE && REG_RD;

    // ------------------------------------------------------------------------
    // Register sets, one per subsystem
    // ------------------------------------------------------------------------
    // Each subsystem keeps its own pair of settings; software selects its pair
    // with the select line, while the access path below reads the pair of
    // whichever side owns the external bus. Write masks keep reserved bits zero.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_set
            always @(posedge REF_CLK) begin
                if (RESET) begin
                    range_set[g] <= `WSG_RANGE_RESET;
                    ctrl_set[g] <= `WSG_CTRL_RESET;
                end else if (wr_en && (REG_SEL_B == (g == 1))) begin
                    if (hit_range)
                        range_set[g] <= REG_WDATA & `WSG_RANGE_WMASK;
                    if (hit_ctrl)
                        ctrl_set[g] <= REG_WDATA & `WSG_CTRL_WMASK;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Reads return the stored word; the reserved control bits are never
    // stored, so they read as zero.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            REG_RDATA <= 16'h0000;
        end else if (rd_en) begin
            if (hit_range)
                REG_RDATA <= range_set[REG_SEL_B];
            else if (hit_ctrl)
                REG_RDATA <= ctrl_set[REG_SEL_B];
            else
                REG_RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------------
    // Access decode and wait generation
    // ------------------------------------------------------------------------
    // The owner is looked at only when an access is accepted, so a change of
    // ownership during a hold leaves the running count alone.
    assign own_range = OWNER_B ? range_set[1] : range_set[0];
    assign own_dbl = OWNER_B ? ctrl_set[1][`WSG_DBL_BIT] : ctrl_set[0][`WSG_DBL_BIT];
    assign next_wait = pick(own_range, ACC_SPACE, ACC_ADDR, own_dbl);
    assign start_ok = ACC_START && !ctr_busy;

    // The counter takes a start only while idle, so a request during a hold
    // is dropped and must be repeated after the done pulse.
    wsg_counter u_counter (
        .clk(REF_CLK),
        .reset(RESET),
        .ce(CE),
        .start(ACC_START),
        .count(next_wait),
        .busy(ctr_busy),
        .done(ctr_done)
    );

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    // Outputs are registered copies of the counter, so the hold and the stall
    // start one cycle after the counter and last exactly as many cycles. The
    // done pulse rises on the edge on which the hold falls.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            BUS_HOLD <= 1'b0;
            CPU_STALL <= 1'b0;
            ACC_DONE <= 1'b0;
            WAIT_COUNT <= 4'h0;
        end else if (CE) begin
            BUS_HOLD <= ctr_busy;
            CPU_STALL <= ctr_busy;
            ACC_DONE <= ctr_done;
            if (start_ok)
                WAIT_COUNT <= next_wait;
        end
    end
endmodule
